// file: bench/analog_front_model.sv
// Analog side model: four channel levels, the shared input mux and the comparator.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic mclk,
    input wire logic [31:0] levels,
    input wire logic [3:0] chan_route,
    input wire logic power_down,
    input wire logic [7:0] dac_code,
    output logic comp_in
);
    logic [7:0] sel_level;
    logic sel_valid;
    logic idle_pattern_ff = 1'b0;

    always_comb begin
        sel_valid = 1'b0;
        sel_level = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (chan_route[i]) begin
                sel_valid = 1'b1;
                sel_level = levels[i*8 +: 8];
            end
        end
    end

    // With no pin routed the comparator sees nothing defined, so it toggles every cycle.
    always_ff @(posedge mclk) begin
        idle_pattern_ff <= ~idle_pattern_ff;
    end

    // A routed level sits half a step above its code, so the trial code equal to it is below.
    assign comp_in = (sel_valid && !power_down) ? (sel_level >= dac_code) : idle_pattern_ff;
endmodule
`default_nettype wire

// file: bench/test_adc_conversion_control.sv
// Self-checking bench for the converter control block with its analog partner model.
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
    import adc_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic stop_mode = 1'b0;
    logic [7:0] rd_data;
    logic comp_in;
    logic [7:0] dac_code;
    logic [3:0] chan_route;
    logic power_down;
    logic conv_wake;
    logic irq;
    logic [31:0] levels = 32'h0;
    int err_count = 0;
    int n_checks = 0;
    int lat;
    logic [7:0] rv;

    always #25 mclk = ~mclk;

    adc_conversion_control i_adc_conversion_control (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .comp_in(comp_in), .stop_mode(stop_mode),
        .dac_code(dac_code), .chan_route(chan_route), .power_down(power_down),
        .conv_wake(conv_wake), .irq(irq)
    );

    analog_front_model i_analog_front_model (
        .mclk(mclk), .levels(levels), .chan_route(chan_route), .power_down(power_down),
        .dac_code(dac_code), .comp_in(comp_in)
    );

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_lat(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("Error at %0t: latency %h outside %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= (a == OFS_STATUS_CONTROL) ? (d & 8'h7f) : d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_rd(a, rv);
        cmp_byte(rv, exp);
    endtask

    // Counts edges after the caller's last edge until the chosen output is seen high.
    task automatic wait_high(input bit use_irq, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (n < 300 && ((use_irq ? irq : conv_wake) !== 1'b1));
        cmp_lat(n, 1, 299);
    endtask

    task automatic wait_flag();
        int k;
        k = 0;
        rv = 8'h00;
        while (k < 60 && rv[BIT_COMPLETE] !== 1'b1) begin
            reg_rd(OFS_STATUS_CONTROL, rv);
            k++;
        end
        cmp_byte({7'h0, rv[BIT_COMPLETE]}, 8'h01);
    endtask

    initial begin
        #(50 * 20000);
        err_count++;
        $display("Error at %0t: watchdog expired, got %h expected %h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end

    initial begin
        void'($urandom(96833));
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(OFS_STATUS_CONTROL, 8'h1f);
        rd_chk(OFS_IRQ_STATUS, 8'h00);
        rd_chk(OFS_IRQ_MASK, 8'h00);
        rd_chk(8'h55, 8'h00);
        reg_wr(OFS_CLOCK_SELECT, 8'hff);
        rd_chk(OFS_CLOCK_SELECT, 8'he0);
        reg_wr(OFS_CLOCK_SELECT, 8'h00);
        #1;
        cmp_byte({power_down, 3'h0, chan_route}, 8'h80);
        $display("Test reset values done");

        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            levels[ch*8 +: 8] = 8'($urandom);
            reg_wr(OFS_STATUS_CONTROL, 8'(ch));
            wait_flag();
            cmp_byte({4'h0, chan_route}, 8'h01 << ch);
            rd_chk(OFS_STATUS_CONTROL, 8'h80 | 8'(ch));
            rd_chk(OFS_RESULT, levels[ch*8 +: 8]);
            rd_chk(OFS_STATUS_CONTROL, 8'(ch));
        end
        cmp_byte({7'h0, irq}, 8'h00);
        rd_chk(OFS_IRQ_STATUS, 8'h01);
        repeat (100) @(posedge mclk);
        rd_chk(OFS_IRQ_STATUS, 8'h00);
        $display("Test single conversions done");

        reg_wr(OFS_IRQ_MASK, 8'h01);
        levels[8 +: 8] = 8'($urandom);
        reg_wr(OFS_STATUS_CONTROL, 8'h41);
        wait_high(0, lat);
        cmp_lat(lat, 62, 66);
        repeat (2) @(posedge mclk);
        #1;
        cmp_byte({7'h0, irq}, 8'h01);
        rd_chk(OFS_STATUS_CONTROL, 8'h41);
        rd_chk(OFS_RESULT, levels[8 +: 8]);
        cmp_byte({7'h0, conv_wake}, 8'h00);
        rd_chk(OFS_IRQ_STATUS, 8'h01);
        reg_wr(OFS_STATUS_CONTROL, 8'h41);
        wait_high(0, lat);
        reg_wr(OFS_STATUS_CONTROL, 8'h40);
        @(posedge mclk);
        #1;
        cmp_byte({7'h0, conv_wake}, 8'h00);
        levels[24 +: 8] = 8'($urandom);
        repeat (30) @(posedge mclk);
        reg_wr(OFS_STATUS_CONTROL, 8'h43);
        wait_high(0, lat);
        cmp_lat(lat, 62, 66);
        rd_chk(OFS_RESULT, levels[24 +: 8]);
        reg_wr(OFS_CLOCK_SELECT, 8'h20);
        reg_wr(OFS_STATUS_CONTROL, 8'h43);
        wait_high(0, lat);
        cmp_lat(lat, 122, 130);
        rd_chk(OFS_RESULT, levels[24 +: 8]);
        reg_wr(OFS_CLOCK_SELECT, 8'h00);
        $display("Test interrupt mode done");

        reg_wr(OFS_IRQ_MASK, 8'h03);
        reg_rd(OFS_IRQ_STATUS, rv);
        reg_wr(OFS_STATUS_CONTROL, 8'h22);
        wait_high(1, lat);
        cmp_lat(lat, 62, 67);
        rd_chk(OFS_IRQ_STATUS, 8'h01);
        levels[16 +: 8] = 8'($urandom);
        wait_high(1, lat);
        rd_chk(OFS_IRQ_STATUS, 8'h03);
        wait_high(1, lat);
        rd_chk(OFS_STATUS_CONTROL, 8'ha2);
        rd_chk(OFS_RESULT, levels[16 +: 8]);
        reg_wr(OFS_STATUS_CONTROL, 8'h02);
        reg_rd(OFS_IRQ_STATUS, rv);
        wait_high(1, lat);
        reg_rd(OFS_IRQ_STATUS, rv);
        repeat (200) @(posedge mclk);
        #1;
        cmp_byte({7'h0, irq}, 8'h00);
        rd_chk(OFS_IRQ_STATUS, 8'h00);
        $display("Test continuous mode done");

        reg_rd(OFS_RESULT, rv);
        levels[8 +: 8] = 8'($urandom);
        reg_wr(OFS_STATUS_CONTROL, 8'h41);
        repeat (20) @(posedge mclk);
        stop_mode <= 1'b1;
        repeat (100) @(posedge mclk);
        stop_mode <= 1'b0;
        #1;
        cmp_byte({7'h0, conv_wake}, 8'h00);
        cmp_byte(dac_code, 8'h00);
        wait_high(0, lat);
        cmp_lat(lat, 61, 70);
        repeat (70) @(posedge mclk);
        rd_chk(OFS_RESULT, levels[8 +: 8]);
        $display("Test stop mode done");

        reg_wr(OFS_STATUS_CONTROL, 8'h1f);
        reg_rd(OFS_IRQ_STATUS, rv);
        repeat (150) @(posedge mclk);
        #1;
        cmp_byte({power_down, 3'h0, chan_route}, 8'h80);
        rd_chk(OFS_IRQ_STATUS, 8'h00);
        reg_wr(OFS_STATUS_CONTROL, 8'h62);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(OFS_STATUS_CONTROL, 8'h1f);
        $display("Test power down and second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: src/adc_conversion_control.sv
// Top of the converter control block: registers, sequencing, low-power handling, interrupts.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control import adc_pkg::*; (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic comp_in,
    input wire logic stop_mode,
    output logic [7:0] dac_code,
    output logic [3:0] chan_route,
    output logic power_down,
    output logic conv_wake,
    output logic irq
);
    typedef struct packed {
        logic comp_meta;
        logic comp_sync;
        logic complete;
        logic irq_en;
        logic cont;
        logic [4:0] chan;
        logic [2:0] clk_sel;
        logic pending;
        logic resume;
        logic stop_q;
        logic conv_req;
        logic unread;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] rd_data;
        logic [3:0] route;
        logic pd;
        logic irq;
    } ctl_s;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    ctl_s cur;
    ctl_s nxt;
    logic [3:0] route_nxt;
    logic wr_ctl;
    logic wr_clk;
    logic wr_mask;
    logic rd_res;
    logic rd_irq;
    logic abort;
    logic stop_enter;
    logic stop_leave;

    conv_if link();

    // Reset is released through two flip-flops so every flop leaves reset on one edge.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign wr_ctl = wr_en && addr == OFS_STATUS_CONTROL;
    assign wr_clk = wr_en && addr == OFS_CLOCK_SELECT;
    assign wr_mask = wr_en && addr == OFS_IRQ_MASK;
    assign rd_res = rd_en && addr == OFS_RESULT;
    assign rd_irq = rd_en && addr == OFS_IRQ_STATUS;
    assign stop_enter = stop_mode && !cur.stop_q;
    assign stop_leave = !stop_mode && cur.stop_q;

    generate
        for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_route
            assign route_nxt[i] = (cur.chan == 5'(i));
        end
    endgenerate

    always_comb begin
        nxt = cur;
        abort = 1'b0;
        nxt.comp_meta = comp_in;
        nxt.comp_sync = cur.comp_meta;
        nxt.stop_q = stop_mode;
        nxt.route = route_nxt;
        nxt.pd = (cur.chan == CH_POWER_DOWN);

        // Clears come first so that a completion in the same cycle wins.
        if (rd_res) begin
            nxt.complete = 1'b0;
            nxt.conv_req = 1'b0;
            nxt.unread = 1'b0;
        end
        if (rd_irq) begin
            nxt.irq_stat = 2'h0;
        end

        if (wr_ctl) begin
            // The completion flag position of the written value is ignored.
            nxt.irq_en = wr_data[BIT_IRQ_EN];
            nxt.cont = wr_data[BIT_CONT];
            nxt.chan = wr_data[CH_MSB:CH_LSB];
            nxt.conv_req = 1'b0;
            if (wr_data[BIT_IRQ_EN]) begin
                nxt.complete = 1'b0;
            end
            // Any running conversion, or one starting in this cycle, is dropped; a fresh one is queued unless the power-down channel is written or stop mode is on.
            abort = 1'b1;
            nxt.pending = (wr_data[CH_MSB:CH_LSB] != CH_POWER_DOWN) && !stop_mode;
        end
        if (wr_clk) begin
            nxt.clk_sel = wr_data[CLK_SEL_MSB:CLK_SEL_LSB];
        end
        if (wr_mask) begin
            nxt.irq_mask = wr_data[1:0];
        end

        if (stop_enter) begin
            abort = 1'b1;
            nxt.resume = link.busy || cur.pending || cur.cont;
            nxt.pending = 1'b0;
        end
        if (stop_leave) begin
            nxt.pending = (cur.resume && !cur.pd) || nxt.pending;
            nxt.resume = 1'b0;
        end

        // The start is held until the engine takes it on a converter tick.
        if (cur.pending && link.tick && !link.busy && !abort && !wr_ctl) begin
            nxt.pending = 1'b0;
        end

        if (link.done) begin
            if (cur.irq_en) begin
                nxt.conv_req = 1'b1;
            end else begin
                nxt.complete = 1'b1;
            end
            nxt.irq_stat[IRQ_BIT_DONE] = 1'b1;
            if (cur.unread) begin
                nxt.irq_stat[IRQ_BIT_OVERRUN] = 1'b1;
            end
            nxt.unread = 1'b1;
            if (cur.cont && !cur.pd && !stop_mode) begin
                nxt.pending = 1'b1;
            end
        end

        nxt.rd_data = 8'h0;
        if (rd_en) begin
            unique case (addr)
                OFS_STATUS_CONTROL: begin
                    nxt.rd_data = {cur.complete && !cur.irq_en, cur.irq_en, cur.cont, cur.chan};
                end
                OFS_RESULT: begin
                    nxt.rd_data = link.result;
                end
                OFS_CLOCK_SELECT: begin
                    nxt.rd_data = {cur.clk_sel, 5'h0};
                end
                OFS_IRQ_STATUS: begin
                    nxt.rd_data = {6'h0, cur.irq_stat};
                end
                OFS_IRQ_MASK: begin
                    nxt.rd_data = {6'h0, cur.irq_mask};
                end
                default: begin
                    nxt.rd_data = 8'h0;
                end
            endcase
        end
        nxt.irq = |(nxt.irq_stat & nxt.irq_mask);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.chan <= RST_CHANNEL;
            cur.clk_sel <= RST_CLOCK_SELECT;
            cur.irq_mask <= RST_IRQ_MASK;
            cur.pd <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    assign link.start = cur.pending;
    assign link.abort = abort;

    conv_clock_div u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .div_sel(cur.clk_sel),
        .run(!stop_mode && !cur.pd),
        .link(link)
    );

    sar_engine u_sar (
        .mclk(mclk),
        .rst_n(rst_n),
        .comp_hi(cur.comp_sync),
        .dac_code(dac_code),
        .link(link)
    );

    assign rd_data = cur.rd_data;
    assign chan_route = cur.route;
    assign power_down = cur.pd;
    // The request keeps running in wait mode and serves as the wake-up source.
    assign conv_wake = cur.conv_req;
    assign irq = cur.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ctl_write;
        wr_ctl && wr_data[CH_MSB:CH_LSB] != CH_POWER_DOWN && !stop_mode;
    endsequence

    sequence s_start_taken;
        cur.pending && link.tick && !link.busy && !stop_mode;
    endsequence

    chk_write_queues: assert property (s_ctl_write |=> cur.pending && !link.busy)
        else $error("control write did not queue a fresh conversion");
    chk_start_tick: assert property (s_start_taken |=> link.busy || $past(wr_ctl))
        else $error("queued start not taken on the converter tick");
    chk_cont_restart: assert property (link.done && cur.cont && !cur.pd && !stop_mode |=> cur.pending)
        else $error("continuous mode did not queue the next conversion");
    chk_single_stop: assert property (link.done && !cur.cont && !wr_ctl |=> !cur.pending)
        else $error("single mode queued another conversion");
    chk_flag_set: assert property (link.done && !cur.irq_en |=> cur.complete)
        else $error("completion flag not set after a conversion");
    chk_flag_zero: assert property (rd_en && addr == OFS_STATUS_CONTROL && cur.irq_en |=> !rd_data[BIT_COMPLETE])
        else $error("completion flag read as one with interrupts enabled");
    chk_req_clear: assert property ((rd_res || wr_ctl) && !link.done |=> !conv_wake)
        else $error("conversion request not cleared by read or write");
    chk_req_raise: assert property (link.done && cur.irq_en |=> conv_wake)
        else $error("conversion request not raised at end of conversion");
    chk_stop_abort: assert property (stop_enter |=> !link.busy [*2])
        else $error("stop mode did not abort the conversion");
endmodule
`default_nettype wire

// file: src/adc_pkg.sv
// Constants, field layouts and types shared by the conversion control block.
package adc_pkg;
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h3c;
    localparam logic [7:0] OFS_RESULT = 8'h3e;
    localparam logic [7:0] OFS_CLOCK_SELECT = 8'h3f;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h41;

    localparam int BIT_COMPLETE = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_CONT = 5;
    localparam int CH_MSB = 4;
    localparam int CH_LSB = 0;
    localparam int CLK_SEL_MSB = 7;
    localparam int CLK_SEL_LSB = 5;
    localparam int IRQ_BIT_DONE = 0;
    localparam int IRQ_BIT_OVERRUN = 1;

    localparam logic [4:0] CH_POWER_DOWN = 5'h1f;
    localparam logic [4:0] RST_CHANNEL = 5'h1f;
    localparam logic [2:0] RST_CLOCK_SELECT = 3'h0;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam int NUM_CHANNELS = 4;

    localparam int MCLK_HZ = 20000000;
    localparam int CONV_CLOCKS = 16;
    localparam logic [3:0] LAST_TICK = 4'(CONV_CLOCKS - 1);
    localparam logic [3:0] SAR_FIRST_CNT = 4'h1;
    localparam logic [3:0] SAR_LAST_CNT = 4'h8;
    localparam logic [7:0] SAR_MSB_CODE = 8'h80;
    localparam logic [9:0] DIV_BASE = 10'h4;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_CONV = 2'b10
    } eng_state_e;
endpackage

// file: src/conv_clock_div.sv
// Divider that makes the converter clock as a one-cycle tick from the bus clock.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div import adc_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] div_sel,
    input wire logic run,
    conv_if.divider link
);
    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
    } div_s;

    div_s cur;
    div_s nxt;
    logic [9:0] last;

    // The period is four bus clocks or more so the synchronised comparator settles.
    assign last = (DIV_BASE << div_sel) - 10'h1;

    always_comb begin
        nxt = cur;
        nxt.tick = 1'b0;
        if (!run) begin
            nxt.cnt = 10'h0;
        end else if (cur.cnt >= last) begin
            nxt.cnt = 10'h0;
            nxt.tick = 1'b1;
        end else begin
            nxt.cnt = cur.cnt + 10'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign link.tick = cur.tick;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_tick_spacing: assert property (cur.tick |=> !cur.tick [*3])
        else $error("converter ticks closer than four bus clocks");
endmodule
`default_nettype wire

// file: src/conv_if.sv
// Link between the control logic, the converter clock divider and the SAR engine.
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
    logic tick;
    logic start;
    logic abort;
    logic done;
    logic busy;
    logic [7:0] result;
    modport ctrl(input tick, done, busy, result, output start, abort);
    modport engine(input tick, start, abort, output done, busy, result);
    modport divider(output tick);
endinterface
`default_nettype wire

// file: src/sar_engine.sv
// Successive approximation sequencer that runs one conversion per start.
`timescale 1ns/1ps
`default_nettype none
module sar_engine import adc_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic comp_hi,
    output logic [7:0] dac_code,
    conv_if.engine link
);
    typedef struct packed {
        eng_state_e st;
        logic [3:0] cnt;
        logic [7:0] code;
        logic [7:0] result;
        logic done;
    } eng_s;

    eng_s cur;
    eng_s nxt;
    logic [4:0] ticks_seen;

    always_comb begin
        logic [2:0] idx;
        idx = 3'h0;
        nxt = cur;
        nxt.done = 1'b0;
        if (link.abort) begin
            nxt.st = ENG_IDLE;
            nxt.cnt = 4'h0;
            nxt.code = 8'h0;
        end else begin
            unique case (cur.st)
                ENG_IDLE: begin
                    if (link.start && link.tick) begin
                        nxt.st = ENG_CONV;
                        nxt.cnt = SAR_FIRST_CNT;
                        nxt.code = SAR_MSB_CODE;
                    end
                end
                ENG_CONV: begin
                    if (link.tick) begin
                        if (cur.cnt >= SAR_FIRST_CNT && cur.cnt <= SAR_LAST_CNT) begin
                            idx = 3'(SAR_LAST_CNT - cur.cnt);
                            nxt.code[idx] = comp_hi;
                            if (idx != 3'h0) begin
                                nxt.code[idx - 3'h1] = 1'b1;
                            end
                        end
                        if (cur.cnt == LAST_TICK) begin
                            nxt.st = ENG_IDLE;
                            nxt.cnt = 4'h0;
                            nxt.done = 1'b1;
                            nxt.result = cur.code;
                        end else begin
                            nxt.cnt = cur.cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    nxt.st = ENG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{st: ENG_IDLE, default: '0};
        end else begin
            cur <= nxt;
        end
    end

    assign link.done = cur.done;
    assign link.busy = (cur.st == ENG_CONV);
    assign link.result = cur.result;
    assign dac_code = cur.code;

    // Counts converter ticks since the start was taken, for the checks only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ticks_seen <= 5'h0;
        end else if (link.abort) begin
            ticks_seen <= 5'h0;
        end else if (cur.st == ENG_IDLE && link.start && link.tick) begin
            ticks_seen <= 5'h1;
        end else if (cur.st == ENG_CONV && link.tick) begin
            ticks_seen <= ticks_seen + 5'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_conv_length: assert property (cur.done |-> ticks_seen == 5'(CONV_CLOCKS))
        else $error("conversion did not last sixteen converter clocks");
    chk_done_pulse: assert property (cur.done |=> !cur.done && cur.st == ENG_IDLE)
        else $error("completion pulse longer than one cycle");
    chk_result_load: assert property (cur.done |-> cur.result == $past(cur.code))
        else $error("result register not loaded with the final code");
endmodule
`default_nettype wire
